// ==== dfloat_r_unit.sv ====
// Purpose: decimal float add A to M / subtract A from M, result in R
// Assumes: memory answers on the same clock; one instruction at a time
// Notes: exponents handled in binary internally, packed back at the end
`include "dfloat_r_map.svh"
`default_nettype none

// Operation
// - add-to-R: accumulator plus memory operand, signed sum left in R
// - copy memory word to R, then compare exponents as signed values
// - unnormalized, difference over eight: larger-exponent operand is result
// - align smaller fraction right; add five to last digit shifted out
// - add overflow: shift R right, insert one at top, exponent plus one
// - fraction subtract: R minus A, keeping R's original sign
// - subtract underflow: invert R fraction sign, complement cycle
// - subtract-from-memory: M minus A; like signs subtract, unlike add
// - out-of-range subtract: accumulator sign negated when it is larger
// - normalize select bit picks unnormalized or normalized mode
// - normalized, difference over fifteen: larger operand, then normalize
// - normalized, difference up to eight: arithmetic then normalize
// - normalized nine to fifteen: prenormalize larger, redecide, normalize
// - keep bits of accumulator and memory word are never altered
module dfloat_r_unit (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire dfloat_r_pkg::op_t op_i,
    input wire dfloat_r_pkg::word_t acc_i,
    input wire logic mem_valid_i,
    input wire dfloat_r_pkg::word_t mem_data_i,
    output logic mem_rd_o,
    output logic busy_o,
    output logic done_o,
    output dfloat_r_pkg::word_t r_word_o,
    output dfloat_r_pkg::word_t a_word_o
);

    ////////////////////////////////////////////////////////////////////////
    // decimal helpers

    function automatic logic [32:0] bcd_add(input logic [31:0] x,
                                            input logic [31:0] y,
                                            input logic cin);
        logic [4:0] s;
        logic c;
        logic [31:0] r;
        c = cin;
        r = `FRAC_RESET;
        for (int i = 0; i < 8; i++) begin
            s = {1'b0, x[i*4 +: 4]} + {1'b0, y[i*4 +: 4]} + {4'h0, c};
            c = (s > 5'd9);
            r[i*4 +: 4] = c ? 4'(s - 5'd10) : s[3:0];
        end
        return {c, r};
    endfunction

    function automatic logic [31:0] nines(input logic [31:0] x);
        logic [31:0] r;
        r = `FRAC_RESET;
        for (int i = 0; i < 8; i++) begin
            r[i*4 +: 4] = `DIGIT_NINE - x[i*4 +: 4];
        end
        return r;
    endfunction

    function automatic logic signed [7:0] exp_int(input dfloat_r_pkg::word_t w);
        logic [7:0] m;
        m = 8'(w.exp[7:4]) * 8'd10 + 8'(w.exp[3:0]);
        return w.esign ? -$signed(m) : $signed(m);
    endfunction

    function automatic logic [8:0] exp_pack(input logic signed [7:0] e);
        logic [7:0] m;
        logic [7:0] t;
        logic [7:0] o;
        m = (e < 0) ? 8'(-e) : 8'(e);
        t = (m / 8'd10) % 8'd10;
        o = m % 8'd10;
        return {(e < 0), t[3:0], o[3:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    dfloat_r_pkg::state_t st_q, st_d;
    dfloat_r_pkg::op_t op_q, op_d;
    dfloat_r_pkg::word_t r_q, r_d, a_q, a_d;
    logic [31:0] fr_q, fr_d, fa_q, fa_d;
    logic signed [7:0] er_q, er_d, ea_q, ea_d;
    logic sr_q, sr_d, sa_q, sa_d;
    logic [3:0] rnd_q, rnd_d;
    logic rnd_a_q, rnd_a_d;
    logic pre_q, pre_d;
    logic mem_rd_q, mem_rd_d, busy_q, busy_d, done_q, done_d;

    logic signed [8:0] dif;
    logic r_big;
    logic norm;
    logic rnd_up;
    logic [31:0] fr_r, fa_r;
    logic [32:0] s;
    logic [8:0] pk;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        st_d = st_q;
        op_d = op_q;
        r_d = r_q;
        a_d = a_q;
        fr_d = fr_q;
        fa_d = fa_q;
        er_d = er_q;
        ea_d = ea_q;
        sr_d = sr_q;
        sa_d = sa_q;
        rnd_d = rnd_q;
        rnd_a_d = rnd_a_q;
        pre_d = pre_q;
        mem_rd_d = mem_rd_q;
        busy_d = busy_q;
        done_d = 1'b0;
        r_big = (er_q >= ea_q);
        dif = r_big ? 9'(er_q) - 9'(ea_q) : 9'(ea_q) - 9'(er_q);
        norm = op_q.normalize_select_bit;
        rnd_up = (rnd_q >= `ROUND_DIGIT);
        fa_r = (rnd_a_q && rnd_up)
            ? 32'(bcd_add(fa_q, 32'h0000_0000, 1'b1)) : fa_q;
        fr_r = (!rnd_a_q && rnd_up)
            ? 32'(bcd_add(fr_q, 32'h0000_0000, 1'b1)) : fr_q;
        s = 33'h0_0000_0000;
        pk = 9'h000;
        case (st_q)
            dfloat_r_pkg::S_IDLE: begin
                if (start_i) begin
                    op_d = op_i;
                    a_d = acc_i;
                    if (op_i.floating_select_bit) begin
                        mem_rd_d = 1'b1;
                        busy_d = 1'b1;
                        st_d = dfloat_r_pkg::S_FETCH;
                    end else begin
                        done_d = 1'b1;
                    end
                end
            end
            dfloat_r_pkg::S_FETCH: begin
                if (mem_valid_i) begin
                    mem_rd_d = 1'b0;
                    r_d = mem_data_i;
                    fr_d = mem_data_i.frac;
                    er_d = exp_int(mem_data_i);
                    sr_d = mem_data_i.fsign;
                    fa_d = a_q.frac;
                    ea_d = exp_int(a_q);
                    sa_d = a_q.fsign ^ op_q.is_sub;
                    rnd_d = `DIGIT_ZERO;
                    rnd_a_d = 1'b0;
                    pre_d = 1'b0;
                    st_d = dfloat_r_pkg::S_CMP;
                end
            end
            dfloat_r_pkg::S_CMP: begin
                if (dif > `NORM_LIMIT
                    || (dif > `ALIGN_LIMIT && (!norm || pre_q))) begin
                    if (!r_big) begin
                        fr_d = fa_q;
                        er_d = ea_q;
                        sr_d = sa_q;
                    end
                    st_d = norm ? dfloat_r_pkg::S_NORM : dfloat_r_pkg::S_DONE;
                end else if (dif > `ALIGN_LIMIT) begin
                    st_d = dfloat_r_pkg::S_PRE;
                end else begin
                    st_d = dfloat_r_pkg::S_ALIGN;
                end
            end
            dfloat_r_pkg::S_PRE: begin
                if (r_big && fr_q[31:28] == `DIGIT_ZERO && fr_q != 0) begin
                    fr_d = {fr_q[27:0], `DIGIT_ZERO};
                    er_d = 8'(er_q - 8'sd1);
                end else if (!r_big && fa_q[31:28] == `DIGIT_ZERO
                             && fa_q != 0) begin
                    fa_d = {fa_q[27:0], `DIGIT_ZERO};
                    ea_d = 8'(ea_q - 8'sd1);
                end else begin
                    pre_d = 1'b1;
                    st_d = dfloat_r_pkg::S_CMP;
                end
            end
            dfloat_r_pkg::S_ALIGN: begin
                if (ea_q < er_q) begin
                    rnd_d = fa_q[3:0];
                    rnd_a_d = 1'b1;
                    fa_d = {`DIGIT_ZERO, fa_q[31:4]};
                    ea_d = 8'(ea_q + 8'sd1);
                end else if (er_q < ea_q) begin
                    rnd_d = fr_q[3:0];
                    rnd_a_d = 1'b0;
                    fr_d = {`DIGIT_ZERO, fr_q[31:4]};
                    er_d = 8'(er_q + 8'sd1);
                end else begin
                    st_d = dfloat_r_pkg::S_ARITH;
                end
            end
            dfloat_r_pkg::S_ARITH: begin
                fa_d = fa_r;
                st_d = norm ? dfloat_r_pkg::S_NORM : dfloat_r_pkg::S_DONE;
                if (sa_q == sr_q) begin
                    s = bcd_add(fr_r, fa_r, 1'b0);
                    fr_d = s[31:0];
                    if (s[32]) begin
                        fr_d = {`OVF_DIGIT, s[31:4]};
                        er_d = 8'(er_q + 8'sd1);
                    end
                end else begin
                    s = bcd_add(fr_r, nines(fa_r), 1'b1);
                    fr_d = s[31:0];
                    if (!s[32]) begin
                        sr_d = ~sr_q;
                        st_d = dfloat_r_pkg::S_COMPL;
                    end
                end
            end
            dfloat_r_pkg::S_COMPL: begin
                s = bcd_add(nines(fr_q), 32'h0000_0000, 1'b1);
                fr_d = s[31:0];
                st_d = norm ? dfloat_r_pkg::S_NORM : dfloat_r_pkg::S_DONE;
            end
            dfloat_r_pkg::S_NORM: begin
                if (fr_q[31:28] == `DIGIT_ZERO && fr_q != 0) begin
                    fr_d = {fr_q[27:0], `DIGIT_ZERO};
                    er_d = 8'(er_q - 8'sd1);
                end else begin
                    st_d = dfloat_r_pkg::S_DONE;
                end
            end
            dfloat_r_pkg::S_DONE: begin
                pk = exp_pack(er_q);
                r_d.frac = fr_q;
                r_d.fsign = sr_q;
                r_d.esign = pk[8];
                r_d.exp = pk[7:0];
                pk = exp_pack(ea_q);
                a_d.frac = fa_q;
                a_d.esign = pk[8];
                a_d.exp = pk[7:0];
                busy_d = 1'b0;
                done_d = 1'b1;
                st_d = dfloat_r_pkg::S_IDLE;
            end
            default: begin
                st_d = dfloat_r_pkg::S_IDLE;
                busy_d = 1'b0;
                mem_rd_d = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_q <= dfloat_r_pkg::S_IDLE;
            op_q <= '0;
            r_q <= `WORD_RESET;
            a_q <= `WORD_RESET;
            fr_q <= `FRAC_RESET;
            fa_q <= `FRAC_RESET;
            er_q <= `EXP_RESET;
            ea_q <= `EXP_RESET;
            sr_q <= 1'b0;
            sa_q <= 1'b0;
            rnd_q <= `DIGIT_ZERO;
            rnd_a_q <= 1'b0;
            pre_q <= 1'b0;
            mem_rd_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            r_q <= r_d;
            a_q <= a_d;
            fr_q <= fr_d;
            fa_q <= fa_d;
            er_q <= er_d;
            ea_q <= ea_d;
            sr_q <= sr_d;
            sa_q <= sa_d;
            rnd_q <= rnd_d;
            rnd_a_q <= rnd_a_d;
            pre_q <= pre_d;
            mem_rd_q <= mem_rd_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign mem_rd_o = mem_rd_q;
    assign busy_o = busy_q;
    assign done_o = done_q;
    assign r_word_o = r_q;
    assign a_word_o = a_q;

endmodule

`default_nettype wire

// ==== dfloat_r_map.svh ====
// Purpose: constants for the decimal float add/sub-to-second-register path
// Assumes: included by its bare name
// Notes: definitions only
`ifndef DFLOAT_R_MAP_SVH
`define DFLOAT_R_MAP_SVH

// exponent difference limits
`define ALIGN_LIMIT 8'sd8
`define NORM_LIMIT 8'sd15
// rounding digit threshold: digit plus five carries when digit >= 5
`define ROUND_DIGIT 4'h5
// character inserted on add overflow
`define OVF_DIGIT 4'h1
`define DIGIT_ZERO 4'h0
`define DIGIT_NINE 4'h9
// reset values
`define WORD_RESET 48'h0000_0000_0000
`define FRAC_RESET 32'h0000_0000
`define EXP_RESET 8'sh00

`endif

// ==== dfloat_r_pkg.sv ====
// Purpose: types for the decimal float add/sub-to-second-register path
// Assumes: fraction of eight decimal characters, two-digit exponent
// Notes: one-hot sequencer states
`default_nettype none

package dfloat_r_pkg;

    // operand word; keep bits pass through untouched
    typedef struct packed {
        logic [5:0] keep;
        logic fsign;
        logic esign;
        logic [7:0] exp;
        logic [31:0] frac;
    } word_t;

    typedef struct packed {
        logic is_sub;
        logic normalize_select_bit;
        logic floating_select_bit;
    } op_t;

    typedef enum logic [8:0] {
        S_IDLE  = 9'h001,
        S_FETCH = 9'h002,
        S_CMP   = 9'h004,
        S_PRE   = 9'h008,
        S_ALIGN = 9'h010,
        S_ARITH = 9'h020,
        S_COMPL = 9'h040,
        S_NORM  = 9'h080,
        S_DONE  = 9'h100
    } state_t;

endpackage

`default_nettype wire

// ==== dfloat_r_chk.sv ====
// Purpose: port checker for the decimal float add/sub-to-R unit
// Assumes: one clock domain, async active-high reset
// Notes: bound to dfloat_r_unit below
`default_nettype none
module dfloat_r_chk (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire dfloat_r_pkg::op_t op_i,
    input wire dfloat_r_pkg::word_t acc_i,
    input wire logic mem_valid_i,
    input wire dfloat_r_pkg::word_t mem_data_i,
    input wire logic mem_rd_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire dfloat_r_pkg::word_t r_word_o,
    input wire dfloat_r_pkg::word_t a_word_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    logic go, take, bcd_ok, norm_q;
    logic [5:0] mk_q, ak_q;
    assign go = start_i && !busy_o;
    assign take = mem_rd_o && mem_valid_i;
    // every R fraction character must be a decimal digit
    always_comb begin
        bcd_ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (r_word_o.frac[4*i +: 4] > 4'h9) begin
                bcd_ok = 1'b0;
            end
        end
    end
    // keep bits and mode of the running instruction
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            mk_q <= 6'h00;
            ak_q <= 6'h00;
            norm_q <= 1'b0;
        end else begin
            if (take) begin
                mk_q <= mem_data_i.keep;
            end
            if (go) begin
                ak_q <= acc_i.keep;
                norm_q <= op_i.normalize_select_bit &&
                    op_i.floating_select_bit;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    a_fetch_start: assert property (go && op_i.floating_select_bit |=>
        mem_rd_o && busy_o) else $error("no fetch after start");
    a_fetch_hold: assert property (mem_rd_o && !mem_valid_i |=>
        mem_rd_o) else $error("read dropped early");
    a_fetch_copy: assert property (take |=> !mem_rd_o &&
        r_word_o == $past(mem_data_i)) else $error("memory word not in r");
    a_rd_idle: assert property (!busy_o |-> !mem_rd_o)
        else $error("read while idle");
    a_acc_take: assert property (go |=> a_word_o == $past(acc_i))
        else $error("accumulator not taken");
    a_no_float: assert property (go && !op_i.floating_select_bit |=>
        !mem_rd_o ##[0:1] done_o) else $error("integer op not passed");
    a_done_bound: assert property (go && op_i.floating_select_bit |->
        ##[3:80] done_o) else $error("no done");
    a_keep_bits: assert property (done_o |-> r_word_o.keep == mk_q &&
        a_word_o.keep == ak_q) else $error("keep bits altered");
    a_norm_top: assert property (done_o && norm_q &&
        r_word_o.frac != 32'h0000_0000 |-> r_word_o.frac[31:28] != 4'h0)
        else $error("result not normalized");
    a_bcd_frac: assert property (done_o |-> bcd_ok)
        else $error("non decimal result");
endmodule

bind dfloat_r_unit dfloat_r_chk dfloat_r_chk_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .start_i(start_i),
    .op_i(op_i), .acc_i(acc_i), .mem_valid_i(mem_valid_i),
    .mem_data_i(mem_data_i), .mem_rd_o(mem_rd_o), .busy_o(busy_o),
    .done_o(done_o), .r_word_o(r_word_o), .a_word_o(a_word_o));
`default_nettype wire

// ==== dfloat_r_mem.sv ====
// Purpose: core memory model answering operand reads
// Assumes: read request held until taken
// Notes: lat_i sets answer delay; released data shows inverted last word
`default_nettype none
module dfloat_r_mem (
    input wire logic clk_sys_i,
    input wire logic rd_i,
    input wire dfloat_r_pkg::word_t word_i,
    input wire logic [1:0] lat_i,
    output var logic valid_o,
    output var dfloat_r_pkg::word_t data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic taken;
    logic [1:0] cnt = 2'h0;
    initial valid_o = 1'b0;
    initial data_o = '0;
    always @(posedge clk_sys_i) begin
        taken = rd_i && valid_o;
        #1;
        if (taken) begin
            valid_o = 1'b0;
            data_o = ~data_o;
        end else if (rd_i && !valid_o) begin
            if (cnt == lat_i) begin
                valid_o = 1'b1;
                data_o = word_i;
                cnt = 2'h0;
            end else begin
                cnt = cnt + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== decimal_float_add_sub_to_r_tb_top.sv ====
// Purpose: self-checking bench for the decimal float add/sub-to-R unit
// Assumes: 125 MHz clock, memory model on the read port
// Notes: expected words worked out by hand
`default_nettype none
module decimal_float_add_sub_to_r_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 0, reset_i = 1, start_i = 0;
    logic mem_valid_i, mem_rd_o, busy_o, done_o;
    logic [1:0] lat_q = 2'h0;
    dfloat_r_pkg::op_t op_i = '0;
    dfloat_r_pkg::word_t acc_i = '0, word_q = '0, res;
    dfloat_r_pkg::word_t mem_data_i, r_word_o, a_word_o;
    int error_cnt = 0, checks_done = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    dfloat_r_unit dfloat_r_unit_i (.clk_sys_i(clk_sys_i),
        .reset_i(reset_i), .start_i(start_i), .op_i(op_i), .acc_i(acc_i),
        .mem_valid_i(mem_valid_i), .mem_data_i(mem_data_i),
        .mem_rd_o(mem_rd_o), .busy_o(busy_o), .done_o(done_o),
        .r_word_o(r_word_o), .a_word_o(a_word_o));
    dfloat_r_mem dfloat_r_mem_i (.clk_sys_i(clk_sys_i), .rd_i(mem_rd_o),
        .word_i(word_q), .lat_i(lat_q), .valid_o(mem_valid_i),
        .data_o(mem_data_i));
    ////////////////////////////////////////////////////////////////////
    function automatic dfloat_r_pkg::word_t mw(int s, int es,
        logic [7:0] e, logic [31:0] f);
        return {6'h2a, 1'(s), 1'(es), e, f};
    endfunction
    function automatic dfloat_r_pkg::word_t aw(int s, int es,
        logic [7:0] e, logic [31:0] f);
        return {6'h15, 1'(s), 1'(es), e, f};
    endfunction
    task automatic chk(input dfloat_r_pkg::word_t got, exp, string nm);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s %h vs %h", $time, nm, got, exp);
        end
        $display("test %s done", nm);
    endtask
    task automatic run(input logic [2:0] op, dfloat_r_pkg::word_t a, m,
        input int lat);
        int n;
        @(posedge clk_sys_i);
        #1;
        op_i = op;
        acc_i = a;
        word_q = m;
        lat_q = 2'(lat);
        start_i = 1'b1;
        @(posedge clk_sys_i);
        #1;
        start_i = 1'b0;
        n = 1;
        while (done_o !== 1'b1 && n < 100) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        if (n == 100) begin
            error_cnt++;
            $display("mismatch at %0t: no done", $time);
        end
        res = r_word_o;
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_unnorm_add;
        run(3'b001, aw(0,1,8'h03,32'h2370_0000), mw(0,0,8'h02,32'h0676_3758), 0);
        chk(res, mw(0,0,8'h02,32'h0676_3995), "add");
        chk(a_word_o, aw(0,0,8'h02,32'h0000_0237), "align");
        run(3'b001, aw(0,0,8'h00,32'h1234_5678), mw(0,0,8'h01,32'h1000_0000), 3);
        chk(res, mw(0,0,8'h01,32'h1123_4568), "round");
        run(3'b001, aw(0,0,8'h00,32'h5000_0000), mw(0,0,8'h08,32'h1000_0000), 1);
        chk(res, mw(0,0,8'h08,32'h1000_0001), "diff8");
        run(3'b001, aw(0,0,8'h00,32'h2000_0000), mw(0,0,8'h00,32'h9000_0000), 0);
        chk(res, mw(0,0,8'h01,32'h1100_0000), "ovf");
        run(3'b001, aw(1,0,8'h00,32'h5000_0000), mw(0,0,8'h00,32'h2000_0000), 2);
        chk(res, mw(1,0,8'h00,32'h3000_0000), "under");
    endtask
    task automatic t_sub;
        run(3'b101, aw(0,0,8'h00,32'h2000_0000), mw(0,0,8'h00,32'h5000_0000), 0);
        chk(res, mw(0,0,8'h00,32'h3000_0000), "sub");
        run(3'b101, aw(1,0,8'h00,32'h6000_0000), mw(0,0,8'h00,32'h5000_0000), 1);
        chk(res, mw(0,0,8'h01,32'h1100_0000), "subadd");
        run(3'b101, aw(0,0,8'h09,32'h2222_2222), mw(0,0,8'h00,32'h1111_1111), 0);
        chk(res, mw(1,0,8'h09,32'h2222_2222), "far");
    endtask
    task automatic t_norm;
        run(3'b011, aw(0,0,8'h00,32'h0000_0500), mw(0,0,8'h00,32'h0000_1000), 0);
        chk(res, mw(0,1,8'h04,32'h1500_0000), "norm");
        run(3'b011, aw(0,0,8'h00,32'h0000_0005), mw(0,0,8'h20,32'h0000_0012), 3);
        chk(res, mw(0,0,8'h14,32'h1200_0000), "normfar");
        run(3'b011, aw(0,0,8'h00,32'h5000_0000), mw(0,0,8'h10,32'h0000_0001), 0);
        chk(res, mw(0,0,8'h03,32'h1005_0000), "normmid");
        run(3'b011, aw(0,0,8'h00,32'h5000_0000),
            mw(0,0,8'h10,32'h1000_0000), 2);
        chk(res, mw(0,0,8'h10,32'h1000_0000), "normstay");
        run(3'b111, aw(0,0,8'h00,32'h3000_0000), mw(0,0,8'h00,32'h3000_0000), 1);
        chk(res, mw(0,0,8'h00,32'h0000_0000), "zero");
    endtask
    task automatic t_nofloat;
        run(3'b010, aw(1,0,8'h05,32'h0000_0009), mw(0,0,8'h00,32'h1111_1111), 0);
        chk(r_word_o, mw(0,0,8'h00,32'h0000_0000), "keep r");
        chk(a_word_o, aw(1,0,8'h05,32'h0000_0009), "keep a");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_sys_i);
        #1;
        reset_i = 1'b0;
        t_unnorm_add();
        t_sub();
        t_norm();
        t_nofloat();
        close_out();
    end
    initial begin
        #20000;
        error_cnt++;
        $display("mismatch at %0t: watchdog", $time);
        close_out();
    end
endmodule
`default_nettype wire
